// ==== rtl/fieldbus_scanner_status_regs.sv ====
// status query and slave-setting register bank of the fieldbus scanner.
// assumes: host accesses by register number with one-cycle rd/wr strobes,
// status vectors come from the scan engine already synchronous to mclk_i.
//
// Function
// R01 - node query reads 1 only if node 0-63 configured and scanning clean
// R02 - digital input query 1-1024 reads 1 when that input data is valid
// R03 - digital output query 1-1024 reads 1 when that output data is valid
// R04 - analog input query 1-128 reads 1 when that channel data is valid
// R05 - analog output query 1-128 reads 1 when that channel data is valid
// R06 - point valid only if network-assigned and its connection active and clean
// R07 - active node address readable in a read-only register
// R08 - bit-rate register reads 0, 1, 2 for 125, 250, 500 kBd
// R09 - switch image: node address low byte, bit-rate setting next byte
// R10 - firmware version reads major times 100 plus minor
// R11 - bit strobe response start register and count are held
// R12 - poll or change_of_state response start and count are writable
// R13 - poll input message start and count are writable
// R14 - slave update register sets refresh cycle in milliseconds
// R15 - zero in slave update register disables slave mode
// R16 - unit serial number readable in a read-only register
// R17 - each query register keeps last index written for later reads
`timescale 1ns/1ps
module fieldbus_scanner_status_regs
  import scanner_regs_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES
)
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic [NODE_COUNT-1:0] node_ok_i,
  input wire logic [DIGITAL_POINTS-1:0] din_assigned_i,
  input wire logic [DIGITAL_POINTS-1:0] din_conn_ok_i,
  input wire logic [DIGITAL_POINTS-1:0] dout_assigned_i,
  input wire logic [DIGITAL_POINTS-1:0] dout_conn_ok_i,
  input wire logic [ANALOG_CHANNELS-1:0] ain_assigned_i,
  input wire logic [ANALOG_CHANNELS-1:0] ain_conn_ok_i,
  input wire logic [ANALOG_CHANNELS-1:0] aout_assigned_i,
  input wire logic [ANALOG_CHANNELS-1:0] aout_conn_ok_i,
  input wire logic [7:0] node_address_i,
  input wire logic [1:0] bit_rate_i,
  input wire logic [7:0] switch_node_address_i,
  input wire logic [7:0] switch_bit_rate_i,
  input wire logic [31:0] unit_serial_i,
  input wire logic [7:0] fw_major_i,
  input wire logic [7:0] fw_minor_i,
  output logic slave_enable_o,
  output logic slave_refresh_o,
  output logic [31:0] strobe_resp_start_o,
  output logic [31:0] strobe_resp_count_o,
  output logic [31:0] poll_resp_start_o,
  output logic [31:0] poll_resp_count_o,
  output logic [31:0] poll_input_start_o,
  output logic [31:0] poll_input_count_o
);

  // ==========================================================
  // query index registers
  logic [31:0] node_idx_reg;
  logic [31:0] din_idx_reg;
  logic [31:0] dout_idx_reg;
  logic [31:0] ain_idx_reg;
  logic [31:0] aout_idx_reg;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      node_idx_reg <= WORD_RESET;
      din_idx_reg <= WORD_RESET;
      dout_idx_reg <= WORD_RESET;
      ain_idx_reg <= WORD_RESET;
      aout_idx_reg <= WORD_RESET;
    end
    else if (reg_wr_i)
    begin
      // last written index sticks, see R17
      unique case (reg_addr_i)
        NODE_HEALTH_QUERY: node_idx_reg <= reg_wdata_i;
        DIGITAL_IN_VALID_QUERY: din_idx_reg <= reg_wdata_i;
        DIGITAL_OUT_VALID_QUERY: dout_idx_reg <= reg_wdata_i;
        ANALOG_IN_VALID_QUERY: ain_idx_reg <= reg_wdata_i;
        ANALOG_OUT_VALID_QUERY: aout_idx_reg <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // per-point validity
  logic [DIGITAL_POINTS-1:0] din_valid;
  logic [DIGITAL_POINTS-1:0] dout_valid;
  logic [ANALOG_CHANNELS-1:0] ain_valid;
  logic [ANALOG_CHANNELS-1:0] aout_valid;

  genvar gi;
  generate
    for (gi = 0; gi < DIGITAL_POINTS; gi++)
    begin : g_point
      assign din_valid[gi] = din_assigned_i[gi] & din_conn_ok_i[gi]; // see R06
      assign dout_valid[gi] = dout_assigned_i[gi] & dout_conn_ok_i[gi]; // see R06
      if (gi < ANALOG_CHANNELS)
      begin : g_analog
        assign ain_valid[gi] = ain_assigned_i[gi] & ain_conn_ok_i[gi]; // see R06
        assign aout_valid[gi] = aout_assigned_i[gi] & aout_conn_ok_i[gi]; // see R06
      end
    end
  endgenerate

  // ==========================================================
  // query answers; out-of-range index answers 0
  logic node_ans;
  logic din_ans;
  logic dout_ans;
  logic ain_ans;
  logic aout_ans;
  logic [9:0] din_bit;
  logic [9:0] dout_bit;
  logic [6:0] ain_bit;
  logic [6:0] aout_bit;

  assign din_bit = 10'(din_idx_reg - POINT_INDEX_MIN);
  assign dout_bit = 10'(dout_idx_reg - POINT_INDEX_MIN);
  assign ain_bit = 7'(ain_idx_reg - POINT_INDEX_MIN);
  assign aout_bit = 7'(aout_idx_reg - POINT_INDEX_MIN);

  // see R01
  assign node_ans = (node_idx_reg <= NODE_INDEX_MAX) && node_ok_i[node_idx_reg[5:0]];
  // see R02
  assign din_ans = (din_idx_reg >= POINT_INDEX_MIN) && (din_idx_reg <= DIGITAL_INDEX_MAX)
                   && din_valid[din_bit];
  // see R03
  assign dout_ans = (dout_idx_reg >= POINT_INDEX_MIN) && (dout_idx_reg <= DIGITAL_INDEX_MAX)
                    && dout_valid[dout_bit];
  // see R04
  assign ain_ans = (ain_idx_reg >= POINT_INDEX_MIN) && (ain_idx_reg <= ANALOG_INDEX_MAX)
                   && ain_valid[ain_bit];
  // see R05
  assign aout_ans = (aout_idx_reg >= POINT_INDEX_MIN) && (aout_idx_reg <= ANALOG_INDEX_MAX)
                    && aout_valid[aout_bit];

  // ==========================================================
  // slave-mode settings
  logic [31:0] strobe_resp_start_reg;
  logic [31:0] strobe_resp_count_reg;
  logic [31:0] poll_resp_start_reg;
  logic [31:0] poll_resp_count_reg;
  logic [31:0] poll_input_start_reg;
  logic [31:0] poll_input_count_reg;
  logic [31:0] slave_update_period_reg;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      strobe_resp_start_reg <= WORD_RESET;
      strobe_resp_count_reg <= WORD_RESET;
      poll_resp_start_reg <= WORD_RESET;
      poll_resp_count_reg <= WORD_RESET;
      poll_input_start_reg <= WORD_RESET;
      poll_input_count_reg <= WORD_RESET;
      slave_update_period_reg <= WORD_RESET;
    end
    else if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        STROBE_RESP_START: strobe_resp_start_reg <= reg_wdata_i; // see R11
        STROBE_RESP_COUNT: strobe_resp_count_reg <= reg_wdata_i; // see R11
        POLL_RESP_START: poll_resp_start_reg <= reg_wdata_i; // see R12
        POLL_RESP_COUNT: poll_resp_count_reg <= reg_wdata_i; // see R12
        POLL_INPUT_START: poll_input_start_reg <= reg_wdata_i; // see R13
        POLL_INPUT_COUNT: poll_input_count_reg <= reg_wdata_i; // see R13
        SLAVE_UPDATE_PERIOD: slave_update_period_reg <= reg_wdata_i; // see R14
        default: ;
      endcase
    end
  end

  assign strobe_resp_start_o = strobe_resp_start_reg;
  assign strobe_resp_count_o = strobe_resp_count_reg;
  assign poll_resp_start_o = poll_resp_start_reg;
  assign poll_resp_count_o = poll_resp_count_reg;
  assign poll_input_start_o = poll_input_start_reg;
  assign poll_input_count_o = poll_input_count_reg;

  // ==========================================================
  // slave refresh timer: ms prescaler then period counter
  logic [31:0] ms_cnt_reg;
  logic [31:0] period_cnt_reg;
  logic slave_enable_reg;
  logic slave_refresh_reg;
  logic ms_tick;
  logic period_zero;

  assign period_zero = (slave_update_period_reg == WORD_RESET);
  assign ms_tick = (ms_cnt_reg == 32'(MS_CYCLES_P - 1));

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      slave_enable_reg <= 1'b0;
    end
    else
    begin
      slave_enable_reg <= !period_zero; // see R15
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i || period_zero || ms_tick)
    begin
      ms_cnt_reg <= WORD_RESET;
    end
    else
    begin
      ms_cnt_reg <= ms_cnt_reg + 32'h00000001;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i || period_zero)
    begin
      // stopped while disabled, see R15
      period_cnt_reg <= WORD_RESET;
      slave_refresh_reg <= 1'b0;
    end
    else if (ms_tick)
    begin
      // one refresh pulse per period milliseconds, see R14
      if (period_cnt_reg >= slave_update_period_reg - 32'h00000001)
      begin
        period_cnt_reg <= WORD_RESET;
        slave_refresh_reg <= 1'b1;
      end
      else
      begin
        period_cnt_reg <= period_cnt_reg + 32'h00000001;
        slave_refresh_reg <= 1'b0;
      end
    end
    else
    begin
      slave_refresh_reg <= 1'b0;
    end
  end

  assign slave_enable_o = slave_enable_reg;
  assign slave_refresh_o = slave_refresh_reg;

  // ==========================================================
  // firmware version word
  logic [15:0] fw_version;
  assign fw_version = 16'(fw_major_i * VERSION_MAJOR_SCALE) + 16'(fw_minor_i); // see R10

  // ==========================================================
  // read path, one cycle after the strobe
  logic [31:0] rdata_next;
  logic [31:0] rdata_reg;
  logic rvalid_reg;

  always_comb
  begin
    rdata_next = WORD_RESET;
    unique case (reg_addr_i)
      NODE_HEALTH_QUERY: rdata_next = {31'h0, node_ans}; // see R01
      DIGITAL_IN_VALID_QUERY: rdata_next = {31'h0, din_ans}; // see R02
      DIGITAL_OUT_VALID_QUERY: rdata_next = {31'h0, dout_ans}; // see R03
      ANALOG_IN_VALID_QUERY: rdata_next = {31'h0, ain_ans}; // see R04
      ANALOG_OUT_VALID_QUERY: rdata_next = {31'h0, aout_ans}; // see R05
      ACTIVE_NODE_ADDRESS: rdata_next = {24'h0, node_address_i}; // see R07
      ACTIVE_BIT_RATE: rdata_next = {30'h0, bit_rate_i}; // see R08
      SWITCH_IMAGE: rdata_next = {16'h0, switch_bit_rate_i, switch_node_address_i}; // see R09
      UNIT_SERIAL: rdata_next = unit_serial_i; // see R16
      FIRMWARE_VERSION: rdata_next = {16'h0, fw_version}; // see R10
      STROBE_RESP_START: rdata_next = strobe_resp_start_reg;
      STROBE_RESP_COUNT: rdata_next = strobe_resp_count_reg;
      POLL_RESP_START: rdata_next = poll_resp_start_reg;
      POLL_RESP_COUNT: rdata_next = poll_resp_count_reg;
      POLL_INPUT_START: rdata_next = poll_input_start_reg;
      POLL_INPUT_COUNT: rdata_next = poll_input_count_reg;
      SLAVE_UPDATE_PERIOD: rdata_next = slave_update_period_reg;
      default: rdata_next = WORD_RESET;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      rdata_reg <= WORD_RESET;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= reg_rd_i;
      if (reg_rd_i)
      begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign reg_rvalid_o = rvalid_reg;

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  sequence write_at(logic [15:0] a);
    reg_wr_i && !reg_rd_i && reg_addr_i == a;
  endsequence

  sequence read_at(logic [15:0] a);
    reg_rd_i && !reg_wr_i && reg_addr_i == a;
  endsequence

  logic node_ok_sel;
  assign node_ok_sel = node_ok_i[reg_wdata_i[5:0]];

  node_query_ok_a: assert property ( // see R01
    (write_at(NODE_HEALTH_QUERY) and reg_wdata_i <= NODE_INDEX_MAX && node_ok_sel)
    ##1 (read_at(NODE_HEALTH_QUERY) and $stable(node_ok_i)) |=> reg_rdata_o == 32'h1)
    else $error("node query did not report a healthy node");

  node_range_a: assert property ( // see R01
    (read_at(NODE_HEALTH_QUERY) and node_idx_reg > NODE_INDEX_MAX) |=> reg_rdata_o == 32'h0)
    else $error("node query out of range not zero");

  din_zero_a: assert property ( // see R02
    (write_at(DIGITAL_IN_VALID_QUERY) and reg_wdata_i == WORD_RESET)
    ##1 read_at(DIGITAL_IN_VALID_QUERY) |=> reg_rdata_o == 32'h0)
    else $error("digital input point zero not reported invalid");

  dout_top_a: assert property ( // see R03
    (write_at(DIGITAL_OUT_VALID_QUERY) and reg_wdata_i == DIGITAL_INDEX_MAX)
    ##1 (read_at(DIGITAL_OUT_VALID_QUERY) and (dout_assigned_i[DIGITAL_POINTS-1]
         && dout_conn_ok_i[DIGITAL_POINTS-1])) |=> reg_rdata_o == 32'h1)
    else $error("digital output point 1024 not reported valid");

  analog_unassigned_a: assert property ( // see R06
    (read_at(ANALOG_IN_VALID_QUERY) and !ain_valid[ain_bit]) or
    (read_at(ANALOG_OUT_VALID_QUERY) and !aout_valid[aout_bit]) |=> reg_rdata_o == 32'h0)
    else $error("analog point reported valid without a live connection");

  query_retain_a: assert property ( // see R17
    write_at(DIGITAL_IN_VALID_QUERY) ##1 !reg_wr_i [*3] |-> din_idx_reg == $past(reg_wdata_i, 3))
    else $error("digital input query index not retained");

  rate_code_a: assert property ( // see R08
    read_at(ACTIVE_BIT_RATE) |=> reg_rdata_o[31:2] == 30'h0
    && reg_rdata_o[1:0] == $past(bit_rate_i))
    else $error("bit-rate code read back wrong");

  switch_layout_a: assert property ( // see R09
    read_at(SWITCH_IMAGE) |=> reg_rdata_o[SWITCH_RATE_LSB +: 8] == $past(switch_bit_rate_i)
    && reg_rdata_o[SWITCH_NODE_LSB +: 8] == $past(switch_node_address_i))
    else $error("switch image layout wrong");

  fw_version_a: assert property ( // see R10
    (read_at(FIRMWARE_VERSION) and (fw_major_i == 8'h02 && fw_minor_i == 8'h14))
    |=> reg_rdata_o == 32'h000000dc)
    else $error("firmware version not major times 100 plus minor");

  slave_disable_a: assert property ( // see R15
    (write_at(SLAVE_UPDATE_PERIOD) and reg_wdata_i == WORD_RESET)
    |=> ##1 !slave_enable_o && !slave_refresh_o)
    else $error("slave mode still active after zero period");

  slave_period_a: assert property ( // see R14
    ms_tick && slave_update_period_reg == 32'h00000001 |=> slave_refresh_o)
    else $error("one-millisecond period gave no refresh");

  strobe_hold_a: assert property ( // see R11
    write_at(STROBE_RESP_COUNT) |=> strobe_resp_count_o == $past(reg_wdata_i))
    else $error("bit strobe count not taken");

endmodule : fieldbus_scanner_status_regs

// ==== rtl/scanner_regs_pkg.sv ====
// register numbers, field layout, reset values and timing of the
// scanner status and slave-setting register bank.
// assumes: one 125 MHz clock, registers addressed by register number.
package scanner_regs_pkg;

  // ==========================================================
  // register numbers
  localparam logic [15:0] NODE_HEALTH_QUERY = 16'h3499;
  localparam logic [15:0] DIGITAL_IN_VALID_QUERY = 16'h349a;
  localparam logic [15:0] DIGITAL_OUT_VALID_QUERY = 16'h349b;
  localparam logic [15:0] ANALOG_IN_VALID_QUERY = 16'h349c;
  localparam logic [15:0] ANALOG_OUT_VALID_QUERY = 16'h349d;
  localparam logic [15:0] ACTIVE_NODE_ADDRESS = 16'h34a8;
  localparam logic [15:0] ACTIVE_BIT_RATE = 16'h34a9;
  localparam logic [15:0] SWITCH_IMAGE = 16'h34aa;
  localparam logic [15:0] UNIT_SERIAL = 16'h34ab;
  localparam logic [15:0] FIRMWARE_VERSION = 16'h34b2;
  localparam logic [15:0] STROBE_RESP_START = 16'h34b3;
  localparam logic [15:0] STROBE_RESP_COUNT = 16'h34b4;
  localparam logic [15:0] POLL_RESP_START = 16'h34b5;
  localparam logic [15:0] POLL_RESP_COUNT = 16'h34b6;
  localparam logic [15:0] POLL_INPUT_START = 16'h34b7;
  localparam logic [15:0] POLL_INPUT_COUNT = 16'h34b8;
  localparam logic [15:0] SLAVE_UPDATE_PERIOD = 16'h34bb;

  // ==========================================================
  // query ranges
  localparam int NODE_COUNT = 64;
  localparam int DIGITAL_POINTS = 1024;
  localparam int ANALOG_CHANNELS = 128;
  localparam logic [31:0] NODE_INDEX_MAX = 32'h0000003f;
  localparam logic [31:0] DIGITAL_INDEX_MAX = 32'h00000400;
  localparam logic [31:0] ANALOG_INDEX_MAX = 32'h00000080;
  localparam logic [31:0] POINT_INDEX_MIN = 32'h00000001;

  // ==========================================================
  // field layout
  localparam int SWITCH_NODE_LSB = 0;
  localparam int SWITCH_RATE_LSB = 8;
  localparam logic [15:0] VERSION_MAJOR_SCALE = 16'h0064;

  // bit-rate codes
  localparam logic [1:0] RATE_125K = 2'h0;
  localparam logic [1:0] RATE_250K = 2'h1;
  localparam logic [1:0] RATE_500K = 2'h2;

  // ==========================================================
  // reset values
  localparam logic [31:0] WORD_RESET = 32'h00000000;

  // ==========================================================
  // timing
  localparam int CLOCK_PERIOD_NS = 8;
  localparam int MILLISECOND_NS = 1000000;
  localparam int MS_CYCLES = MILLISECOND_NS / CLOCK_PERIOD_NS;

endpackage : scanner_regs_pkg

// ==== tb/scan_engine_model.sv ====
// far-side model: scan engine status vectors and module identity.
// assumes: levels only, changed by the bench after a clock edge.
`timescale 1ns/1ps
module scan_engine_model
  import scanner_regs_pkg::*;
(
  input wire logic flip_i,
  input wire logic [1:0] rate_sel_i,
  output logic [NODE_COUNT-1:0] node_ok_o,
  output logic [DIGITAL_POINTS-1:0] din_a_o,
  output logic [DIGITAL_POINTS-1:0] din_c_o,
  output logic [DIGITAL_POINTS-1:0] dout_a_o,
  output logic [DIGITAL_POINTS-1:0] dout_c_o,
  output logic [ANALOG_CHANNELS-1:0] ain_a_o,
  output logic [ANALOG_CHANNELS-1:0] ain_c_o,
  output logic [ANALOG_CHANNELS-1:0] aout_a_o,
  output logic [ANALOG_CHANNELS-1:0] aout_c_o,
  output logic [7:0] node_addr_o,
  output logic [1:0] bit_rate_o,
  output logic [7:0] sw_node_o,
  output logic [7:0] sw_rate_o,
  output logic [31:0] serial_o,
  output logic [7:0] fw_major_o,
  output logic [7:0] fw_minor_o
);
  // ==========================================================
  // status vectors, node health and digital input connection state invert on request
  assign node_ok_o = {4{16'hc3a5}} ^ {NODE_COUNT{flip_i}};
  assign din_a_o = {64{16'hff0f}};
  assign din_c_o = {64{16'h3cf5}} ^ {DIGITAL_POINTS{flip_i}};
  assign dout_a_o = {64{16'h8ff3}};
  assign dout_c_o = {64{16'hd5aa}};
  assign ain_a_o = {8{16'h7e5a}};
  assign ain_c_o = {8{16'hf0cc}};
  assign aout_a_o = {8{16'h3c96}};
  assign aout_c_o = {8{16'hff3b}};
  // ==========================================================
  // identity, serial value arbitrary
  assign node_addr_o = 8'h2a;
  assign bit_rate_o = rate_sel_i;
  assign sw_node_o = 8'h15;
  assign sw_rate_o = 8'h02;
  assign serial_o = 32'h5eed0101;
  assign fw_major_o = 8'h02;
  assign fw_minor_o = 8'h14;
endmodule : scan_engine_model

// ==== tb/tb_fieldbus_scanner_status_regs.sv ====
// self-checking bench of the scanner status register bank.
// assumes: scan_engine_model supplies status and identity levels.
`timescale 1ns/1ps
module tb_fieldbus_scanner_status_regs
  import scanner_regs_pkg::*;
;
  localparam int MSC = 10;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h00000000;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic flip = 1'b0;
  logic [1:0] rate_sel = 2'h0;
  logic [NODE_COUNT-1:0] node_ok;
  logic [DIGITAL_POINTS-1:0] din_a, din_c, dout_a, dout_c;
  logic [ANALOG_CHANNELS-1:0] ain_a, ain_c, aout_a, aout_c;
  logic [7:0] node_addr, sw_node, sw_rate, fw_major, fw_minor;
  logic [1:0] bit_rate;
  logic [31:0] serial;
  logic slave_enable, slave_refresh;
  logic [31:0] cfg_out[6];
  logic [15:0] cfg_addr[6] = '{STROBE_RESP_START, STROBE_RESP_COUNT, POLL_RESP_START,
    POLL_RESP_COUNT, POLL_INPUT_START, POLL_INPUT_COUNT};
  logic [15:0] ro_addr[5] = '{ACTIVE_NODE_ADDRESS, SWITCH_IMAGE, UNIT_SERIAL,
    FIRMWARE_VERSION, 16'h34a0};
  logic [1:0] rates[3] = '{RATE_125K, RATE_250K, RATE_500K};
  int err_count = 0;
  int checks_done = 0;

  always #4 mclk_i = ~mclk_i;

  scan_engine_model u_model (.flip_i(flip), .rate_sel_i(rate_sel), .node_ok_o(node_ok),
    .din_a_o(din_a), .din_c_o(din_c), .dout_a_o(dout_a), .dout_c_o(dout_c),
    .ain_a_o(ain_a), .ain_c_o(ain_c), .aout_a_o(aout_a), .aout_c_o(aout_c),
    .node_addr_o(node_addr), .bit_rate_o(bit_rate), .sw_node_o(sw_node),
    .sw_rate_o(sw_rate), .serial_o(serial), .fw_major_o(fw_major), .fw_minor_o(fw_minor));

  fieldbus_scanner_status_regs #(.MS_CYCLES_P(MSC)) u_dut (.mclk_i(mclk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata),
    .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid), .node_ok_i(node_ok),
    .din_assigned_i(din_a), .din_conn_ok_i(din_c), .dout_assigned_i(dout_a),
    .dout_conn_ok_i(dout_c), .ain_assigned_i(ain_a), .ain_conn_ok_i(ain_c),
    .aout_assigned_i(aout_a), .aout_conn_ok_i(aout_c), .node_address_i(node_addr),
    .bit_rate_i(bit_rate), .switch_node_address_i(sw_node), .switch_bit_rate_i(sw_rate),
    .unit_serial_i(serial), .fw_major_i(fw_major), .fw_minor_i(fw_minor),
    .slave_enable_o(slave_enable), .slave_refresh_o(slave_refresh),
    .strobe_resp_start_o(cfg_out[0]), .strobe_resp_count_o(cfg_out[1]),
    .poll_resp_start_o(cfg_out[2]), .poll_resp_count_o(cfg_out[3]),
    .poll_input_start_o(cfg_out[4]), .poll_input_count_o(cfg_out[5]));

  // ==========================================================
  // access tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want)
    begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic reg_write(input logic [15:0] addr, input logic [31:0] data);
    @(posedge mclk_i);
    reg_wr <= 1'b1;
    reg_addr <= addr;
    reg_wdata <= data;
    @(posedge mclk_i);
    reg_wr <= 1'b0;
  endtask : reg_write

  // answer must stand exactly one cycle after the strobe edge
  task automatic rd_chk(input logic [15:0] addr, input logic [31:0] want);
    @(posedge mclk_i);
    reg_rd <= 1'b1;
    reg_addr <= addr;
    @(posedge mclk_i);
    reg_rd <= 1'b0;
    #1;
    check(reg_rvalid === 1'b1 ? reg_rdata : 32'hxxxxxxxx, want);
  endtask : rd_chk

  function automatic logic [31:0] point_want(input logic [DIGITAL_POINTS-1:0] a,
    input logic [DIGITAL_POINTS-1:0] c, input int k, input int hi);
    if (k < 1 || k > hi)
      return 32'h00000000;
    return {31'h0, a[k-1] & c[k-1]};
  endfunction : point_want

  // index write and read back to back, as the bank allows
  task automatic query(input logic [15:0] addr, input int k, input logic [31:0] want);
    @(posedge mclk_i);
    reg_wr <= 1'b1;
    reg_addr <= addr;
    reg_wdata <= 32'(k);
    @(posedge mclk_i);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge mclk_i);
    reg_rd <= 1'b0;
    #1;
    check(reg_rvalid === 1'b1 ? reg_rdata : 32'hxxxxxxxx, want);
  endtask : query

  task automatic results;
    $display("mismatches %0d, checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  // ==========================================================
  // tests
  initial
  begin : main
    int n;
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++)
      rd_chk(cfg_addr[i], WORD_RESET);
    rd_chk(SLAVE_UPDATE_PERIOD, WORD_RESET);
    check({31'h0, slave_enable}, 32'h0);
    for (int k = 0; k <= NODE_COUNT; k++)
      query(NODE_HEALTH_QUERY, k, k < NODE_COUNT ? {31'h0, node_ok[k]} : 32'h0);
    for (int i = 0; i < 12; i++)
    begin
      n = (i < 9) ? i : DIGITAL_POINTS + i - 10;
      query(DIGITAL_IN_VALID_QUERY, n, point_want(din_a, din_c, n, DIGITAL_POINTS));
      query(DIGITAL_OUT_VALID_QUERY, n, point_want(dout_a, dout_c, n, DIGITAL_POINTS));
      n = (i < 9) ? i : ANALOG_CHANNELS + i - 10;
      query(ANALOG_IN_VALID_QUERY, n,
        point_want(1024'(ain_a), 1024'(ain_c), n, ANALOG_CHANNELS));
      query(ANALOG_OUT_VALID_QUERY, n,
        point_want(1024'(aout_a), 1024'(aout_c), n, ANALOG_CHANNELS));
    end
    // stored index kept, status read live
    reg_write(NODE_HEALTH_QUERY, 32'h00000003);
    reg_write(DIGITAL_IN_VALID_QUERY, 32'h00000005);
    rd_chk(NODE_HEALTH_QUERY, {31'h0, node_ok[3]});
    @(posedge mclk_i);
    flip <= 1'b1;
    #1;
    rd_chk(NODE_HEALTH_QUERY, {31'h0, node_ok[3]});
    rd_chk(DIGITAL_IN_VALID_QUERY, {31'h0, din_a[4] & din_c[4]});
    for (int r = 0; r < 3; r++)
    begin
      @(posedge mclk_i);
      rate_sel <= rates[r];
      rd_chk(ACTIVE_BIT_RATE, {30'h0, rates[r]});
    end
    // read-only words survive a write attempt
    for (int p = 0; p < 2; p++)
    begin
      rd_chk(ACTIVE_NODE_ADDRESS, {24'h0, node_addr});
      rd_chk(SWITCH_IMAGE, {16'h0, sw_rate, sw_node});
      rd_chk(UNIT_SERIAL, serial);
      rd_chk(FIRMWARE_VERSION,
        32'(fw_major) * 32'(VERSION_MAJOR_SCALE) + 32'(fw_minor));
      rd_chk(16'h34a0, 32'h00000000);
      for (int i = 0; i < 5; i++)
        reg_write(ro_addr[i], 32'hffffffff);
    end
    for (int i = 0; i < 6; i++)
      reg_write(cfg_addr[i], 32'h00001000 + 32'(i));
    for (int i = 0; i < 6; i++)
    begin
      rd_chk(cfg_addr[i], 32'h00001000 + 32'(i));
      check(cfg_out[i], 32'h00001000 + 32'(i));
    end
    // slave refresh period and disable
    for (int p = 3; p > 0; p -= 2)
    begin
      reg_write(SLAVE_UPDATE_PERIOD, 32'(p));
      repeat (2) @(posedge mclk_i);
      #1;
      check({31'h0, slave_enable}, 32'h1);
      rd_chk(SLAVE_UPDATE_PERIOD, 32'(p));
      n = 0;
      while (slave_refresh !== 1'b1 && n < 200)
      begin
        @(posedge mclk_i);
        #1;
        n++;
      end
      @(posedge mclk_i);
      #1;
      n = 1;
      while (slave_refresh !== 1'b1 && n < 200)
      begin
        @(posedge mclk_i);
        #1;
        n++;
      end
      check(32'(n), 32'(p * MSC));
    end
    reg_write(SLAVE_UPDATE_PERIOD, 32'h00000000);
    repeat (2) @(posedge mclk_i);
    #1;
    check({31'h0, slave_enable}, 32'h0);
    n = 0;
    repeat (100)
    begin
      @(posedge mclk_i);
      #1;
      if (slave_refresh === 1'b1)
        n++;
    end
    check(32'(n), 32'h0);
    results();
  end

  initial
  begin : watchdog
    repeat (20000) @(posedge mclk_i);
    err_count++;
    results();
  end
endmodule : tb_fieldbus_scanner_status_regs
